// [verilog/mapper_healer_consts.vh]
// constants for the interleaved dram mapper and healer
`ifndef MAPPER_HEALER_CONSTS_VH
`define MAPPER_HEALER_CONSTS_VH
// ------------------------------------------------------------
// register byte offsets (haddr[11:0])
// ------------------------------------------------------------
`define MAP_OFS 12'h000
`define STAT_OFS 12'h004
`define HCAM_BASE 12'h080
`define HRAM_BASE 12'h100
`define ENTRY_BLK 12'h080
// ------------------------------------------------------------
// mapper entry fields and reset value
// ------------------------------------------------------------
`define MAP_OUT_BIT 0
`define MATCH_LO 3
`define MATCH_HI 11
`define MODE_LO 9
`define MODE_HI 11
`define POS_LO 12
`define POS_HI 14
`define MAP_RESET 32'h00000001
`define MODE_TWO 3'h1
`define MODE_FOUR 3'h2
`define MODE_EIGHT 3'h3
// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define ST_OVF_BIT 0
`define ST_FATAL_BIT 1
`define ST_CNT_LO 8
`define ST_CNT_HI 13
// ------------------------------------------------------------
// healer geometry and timing
// ------------------------------------------------------------
`define HEAL_N 32
`define CLK_MHZ 200
`define T_ROW_NS 15
`define T_COL_NS 15
`define T_PRE_NS 20
`define ROW_CYC ((`T_ROW_NS * `CLK_MHZ + 999) / 1000)
`define COL_CYC ((`T_COL_NS * `CLK_MHZ + 999) / 1000)
`define PRE_CYC ((`T_PRE_NS * `CLK_MHZ + 999) / 1000)
`endif

// [verilog/hamming_codec.v]
// seven-bit hamming sec-ded encoder and decoder for 32-bit words
`timescale 1ns/100ps
module hamming_codec
(
    input wire [31:0] enc_data,
    output reg [6:0] enc_check,
    input wire [31:0] dec_data,
    input wire [6:0] dec_check,
    output reg [31:0] dec_fixed,
    output reg dec_single,
    output reg dec_double
);
    integer i;
    integer j;
    integer p;
    reg [5:0] syn;
    reg overall;
    always @*
    begin
        enc_check = 7'h00;
        syn = dec_check[5:0];
        p = 3;
        for (i = 0; i < 32; i = i + 1)
        begin
            for (j = 0; j < 6; j = j + 1)
            begin
                if (p[j])
                begin
                    enc_check[j] = enc_check[j] ^ enc_data[i];
                    syn[j] = syn[j] ^ dec_data[i];
                end
            end
            p = p + 1;
            if ((p & (p - 1)) == 0)
                p = p + 1;
        end
        enc_check[6] = (^enc_data) ^ (^enc_check[5:0]);
        overall = (^dec_data) ^ (^dec_check);
        dec_single = overall;
        dec_double = !overall && (syn != 6'h00);
        dec_fixed = dec_data;
        p = 3;
        for (i = 0; i < 32; i = i + 1)
        begin
            if (overall && (syn == p[5:0]))
                dec_fixed[i] = !dec_data[i];
            p = p + 1;
            if ((p & (p - 1)) == 0)
                p = p + 1;
        end
    end
endmodule // hamming_codec

// [verilog/interleaved_dram_mapper_healer.v]
// dram controller with mapper entry, interleave decode, ecc and healer
`timescale 1ns/100ps
`include "mapper_healer_consts.vh"
module interleaved_dram_mapper_healer
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire pmb_valid,
    input wire pmb_write,
    input wire [29:0] pmb_addr,
    input wire [31:0] pmb_wdata,
    output wire pmb_busy,
    output reg pmb_ack,
    output reg [31:0] pmb_rdata,
    output reg pmb_fatal,
    output reg [8:0] mem_addr,
    output reg row_strobe_n,
    output reg column_strobe_n,
    output reg write_select_n,
    output reg [38:0] mem_dq_o,
    output reg mem_dq_oe,
    input wire [38:0] mem_dq_i
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ROW = 2'h1;
    localparam [1:0] ST_COL = 2'h2;
    localparam [1:0] ST_PRE = 2'h3;

    reg [31:0] map_q;
    reg [18:0] hcam_q [0:31];
    reg [31:0] hram_q [0:31];
    reg [1:0] state_q;
    reg [3:0] cnt_q;
    reg wr_q;
    reg [17:0] phys_q;
    reg [31:0] wdata_q;
    reg rd_pend_q;
    reg wr_pend_q;
    reg [11:0] bus_addr_q;
    wire [31:0] hit_vec;
    wire [31:0] free_vec;
    reg hit;
    reg [4:0] hit_idx;
    reg [4:0] free_idx;
    reg [5:0] used_cnt;
    reg mine;
    reg [31:0] rd_val;
    wire full;
    wire [6:0] enc_check;
    wire [31:0] dec_fixed;
    wire dec_single;
    wire dec_double;
    wire [2:0] mode;
    wire [17:0] pmb_phys;
    wire bus_take;
    wire [4:0] bus_idx;
    wire in_cam;
    wire in_ram;
    wire col_end;
    wire fatal_clr;
    integer k;
    integer r;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign hresp = 1'b0;
    assign hreadyout = !rd_pend_q;
    assign bus_take = hsel && hready && htrans[1];
    assign bus_idx = bus_addr_q[6:2];
    assign in_cam = (bus_addr_q & ~12'h07f) == `HCAM_BASE;
    assign in_ram = (bus_addr_q & ~12'h07f) == `HRAM_BASE;
    assign fatal_clr = wr_pend_q && (bus_addr_q == `STAT_OFS) && hwdata[`ST_FATAL_BIT];

    // ------------------------------------------------------------
    // address mapping
    // ------------------------------------------------------------
    assign mode = map_q[`MODE_HI:`MODE_LO];
    assign pmb_phys = pmb_addr[29:12];
    always @*
    begin
        mine = pmb_addr[`MATCH_HI:`MATCH_LO] == map_q[`MATCH_HI:`MATCH_LO];
        case (mode)
            `MODE_TWO:
                mine = mine && (pmb_addr[0] == map_q[`POS_LO]);
            `MODE_FOUR:
                mine = mine && (pmb_addr[1:0] == map_q[`POS_LO+1:`POS_LO]);
            `MODE_EIGHT:
                mine = mine && (pmb_addr[2:0] == map_q[`POS_HI:`POS_LO]);
            default:
                mine = mine;
        endcase
        if (map_q[`MAP_OUT_BIT])
            mine = 1'b0;
    end

    // ------------------------------------------------------------
    // healer match and allocation
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `HEAL_N; g = g + 1)
        begin : heal_cmp
            assign hit_vec[g] = hcam_q[g][0] && (hcam_q[g][18:1] == phys_q);
            assign free_vec[g] = !hcam_q[g][0];
        end
    endgenerate
    assign full = free_vec == 32'h00000000;

    always @*
    begin
        hit = 1'b0;
        hit_idx = 5'h00;
        free_idx = 5'h00;
        used_cnt = 6'h00;
        for (k = `HEAL_N - 1; k >= 0; k = k - 1)
        begin
            if (hit_vec[k])
            begin
                hit = 1'b1;
                hit_idx = k[4:0];
            end
            if (free_vec[k])
                free_idx = k[4:0];
            else
                used_cnt = used_cnt + 6'h01;
        end
    end

    hamming_codec u_codec
    (
        .enc_data(wdata_q),
        .enc_check(enc_check),
        .dec_data(mem_dq_i[31:0]),
        .dec_check(mem_dq_i[38:32]),
        .dec_fixed(dec_fixed),
        .dec_single(dec_single),
        .dec_double(dec_double)
    );

    // ------------------------------------------------------------
    // dram sequencer
    // ------------------------------------------------------------
    assign pmb_busy = state_q != ST_IDLE;
    assign col_end = (state_q == ST_COL) && (cnt_q == `COL_CYC - 1);

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            wr_q <= 1'b0;
            phys_q <= 18'h00000;
            wdata_q <= 32'h00000000;
            pmb_ack <= 1'b0;
            pmb_rdata <= 32'h00000000;
            mem_addr <= 9'h000;
            row_strobe_n <= 1'b1;
            column_strobe_n <= 1'b1;
            write_select_n <= 1'b1;
            mem_dq_o <= 39'h0000000000;
            mem_dq_oe <= 1'b0;
        end
        else
        begin
            pmb_ack <= 1'b0;
            cnt_q <= cnt_q + 4'h1;
            case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= 4'h0;
                    if (pmb_valid && mine && !pmb_fatal)
                    begin
                        state_q <= ST_ROW;
                        wr_q <= pmb_write;
                        phys_q <= pmb_phys;
                        wdata_q <= pmb_wdata;
                        mem_addr <= pmb_phys[17:9];
                        row_strobe_n <= 1'b0;
                    end
                end
                ST_ROW:
                begin
                    if (cnt_q == `ROW_CYC - 1)
                    begin
                        state_q <= ST_COL;
                        cnt_q <= 4'h0;
                        mem_addr <= phys_q[8:0];
                        column_strobe_n <= 1'b0;
                        write_select_n <= !wr_q;
                        mem_dq_o <= {enc_check, wdata_q};
                        mem_dq_oe <= wr_q;
                    end
                end
                ST_COL:
                begin
                    if (col_end)
                    begin
                        state_q <= ST_PRE;
                        cnt_q <= 4'h0;
                        pmb_ack <= 1'b1;
                        if (!wr_q)
                            pmb_rdata <= hit ? hram_q[hit_idx] : dec_fixed;
                        row_strobe_n <= 1'b1;
                        column_strobe_n <= 1'b1;
                        write_select_n <= 1'b1;
                        mem_dq_oe <= 1'b0;
                    end
                end
                ST_PRE:
                begin
                    if (cnt_q == `PRE_CYC - 1)
                    begin
                        state_q <= ST_IDLE;
                        cnt_q <= 4'h0;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // fatal flag, set wins over clear
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pmb_fatal <= 1'b0;
        else if (col_end && !wr_q && !hit && dec_double)
            pmb_fatal <= 1'b1;
        else if (fatal_clr)
            pmb_fatal <= 1'b0;
    end

    // ------------------------------------------------------------
    // mapper and healer storage
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            map_q <= `MAP_RESET;
            for (r = 0; r < `HEAL_N; r = r + 1)
            begin
                hcam_q[r] <= 19'h00000;
                hram_q[r] <= 32'h00000000;
            end
        end
        else
        begin
            if (wr_pend_q && (bus_addr_q == `MAP_OFS))
                map_q <= hwdata;
            if (wr_pend_q && in_cam)
                hcam_q[bus_idx] <= hwdata[18:0];
            if (wr_pend_q && in_ram)
                hram_q[bus_idx] <= hwdata;
            if (col_end && wr_q && hit)
                hram_q[hit_idx] <= wdata_q;
            if (col_end && !wr_q && !hit && dec_single && !full)
            begin
                hcam_q[free_idx] <= {phys_q, 1'b1};
                hram_q[free_idx] <= dec_fixed;
            end
        end
    end

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    always @*
    begin
        rd_val = 32'h00000000;
        if (bus_addr_q == `MAP_OFS)
            rd_val = map_q;
        else if (bus_addr_q == `STAT_OFS)
        begin
            rd_val[`ST_OVF_BIT] = full;
            rd_val[`ST_FATAL_BIT] = pmb_fatal;
            rd_val[`ST_CNT_HI:`ST_CNT_LO] = used_cnt;
        end
        else if (in_cam)
            rd_val = {13'h0000, hcam_q[bus_idx]};
        else if (in_ram)
            rd_val = hram_q[bus_idx];
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_pend_q <= 1'b0;
            wr_pend_q <= 1'b0;
            bus_addr_q <= 12'h000;
            hrdata <= 32'h00000000;
        end
        else
        begin
            wr_pend_q <= 1'b0;
            if (rd_pend_q)
            begin
                rd_pend_q <= 1'b0;
                hrdata <= rd_val;
            end
            else if (bus_take)
            begin
                bus_addr_q <= haddr[11:0];
                rd_pend_q <= !hwrite;
                wr_pend_q <= hwrite;
            end
        end
    end
endmodule // interleaved_dram_mapper_healer

// [dv/dram_array_model.sv]
// dram chip array model behind the multiplexed address and strobes
`timescale 1ns/100ps
module dram_array_model
(
    input wire hclk,
    input wire [8:0] mem_addr,
    input wire row_strobe_n,
    input wire column_strobe_n,
    input wire write_select_n,
    input wire [38:0] mem_dq_o,
    input wire mem_dq_oe,
    input wire [38:0] flip,
    output logic [38:0] mem_dq_i
);
    logic [38:0] mem [logic [17:0]];
    logic [8:0] row;
    logic [17:0] k;
    initial mem_dq_i = 39'h0;
    always @(posedge hclk)
    begin
        k = {row, mem_addr};
        if (!row_strobe_n && column_strobe_n)
            row = mem_addr;
        if (!row_strobe_n && !column_strobe_n && !write_select_n && mem_dq_oe)
            mem[k] = mem_dq_o;
        else if (!row_strobe_n && !column_strobe_n)
            mem_dq_i <= (mem.exists(k) ? mem[k] : 39'h0) ^ flip;
        else
            mem_dq_i <= ~mem_dq_i;
    end
endmodule // dram_array_model

// [dv/interleaved_dram_mapper_healer_assertions.sv]
// port checker for the dram mapper and healer
`timescale 1ns/100ps
module interleaved_dram_mapper_healer_assertions
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire pmb_valid,
    input wire pmb_write,
    input wire [29:0] pmb_addr,
    input wire [31:0] pmb_wdata,
    input wire pmb_busy,
    input wire pmb_ack,
    input wire [31:0] pmb_rdata,
    input wire pmb_fatal,
    input wire [8:0] mem_addr,
    input wire row_strobe_n,
    input wire column_strobe_n,
    input wire write_select_n,
    input wire [38:0] mem_dq_o,
    input wire mem_dq_oe,
    input wire [38:0] mem_dq_i
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence row_phase;
        $stable(mem_addr) && !row_strobe_n && column_strobe_n;
    endsequence
    sequence access_done;
        !pmb_ack [*6] ##1 pmb_ack;
    endsequence
    sequence busy_span;
        pmb_busy ##4 !pmb_busy;
    endsequence
    chk_row_first: assert property (
        $fell(row_strobe_n) |=> row_phase [*2] ##1 $fell(column_strobe_n))
        else $error("column phase not three cycles after row");
    chk_ack_time: assert property ($fell(row_strobe_n) |-> access_done)
        else $error("ack not six cycles after row strobe");
    chk_col_in_row: assert property (!column_strobe_n |-> !row_strobe_n)
        else $error("column strobe outside row strobe");
    chk_write_drive: assert property (!write_select_n |-> mem_dq_oe && !column_strobe_n)
        else $error("write line low without data drive");
    chk_drive_write: assert property (mem_dq_oe |-> !write_select_n)
        else $error("data driven on a read");
    chk_precharge: assert property (pmb_ack |-> row_strobe_n [*4])
        else $error("row strobe within precharge");
    chk_fatal_ack: assert property ($rose(pmb_fatal) |-> pmb_ack)
        else $error("fatal raised outside a read ack");
    chk_fatal_halt: assert property (pmb_fatal && row_strobe_n |=> row_strobe_n)
        else $error("access started while fatal");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    chk_read_wait: assert property (!hreadyout |=> hreadyout)
        else $error("more than one wait state");
    chk_busy_span: assert property ($rose(pmb_busy) |-> $fell(row_strobe_n) ##6 busy_span)
        else $error("busy not covering access and precharge");
    chk_row_addr: assert property ($fell(row_strobe_n) |-> mem_addr == pmb_addr[29:21])
        else $error("row half not on address bus with row strobe");
    chk_col_addr: assert property ($fell(column_strobe_n) |-> mem_addr == pmb_addr[20:12])
        else $error("column half not on address bus with column strobe");
endmodule // interleaved_dram_mapper_healer_assertions
bind interleaved_dram_mapper_healer interleaved_dram_mapper_healer_assertions u_chk
(
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .pmb_valid, .pmb_write, .pmb_addr, .pmb_wdata, .pmb_busy, .pmb_ack,
    .pmb_rdata, .pmb_fatal, .mem_addr, .row_strobe_n, .column_strobe_n, .write_select_n,
    .mem_dq_o, .mem_dq_oe, .mem_dq_i
);

// [dv/tb.sv]
// self-checking testbench for the dram mapper and healer
`timescale 1ns/100ps
`include "mapper_healer_consts.vh"
module tb;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic pmb_valid = 1'b0, pmb_write = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, pmb_wdata = 32'h0;
    logic [29:0] pmb_addr = 30'h0;
    logic [38:0] flip = 39'h0;
    wire hready, hreadyout, hresp, pmb_busy, pmb_ack, pmb_fatal, mem_dq_oe;
    wire row_strobe_n, column_strobe_n, write_select_n;
    wire [31:0] hrdata, pmb_rdata;
    wire [8:0] mem_addr;
    wire [38:0] mem_dq_o, mem_dq_i;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    int num_errors = 0;
    int n_checks = 0;
    assign hready = hreadyout;
    interleaved_dram_mapper_healer u_interleaved_dram_mapper_healer
    (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .pmb_valid, .pmb_write, .pmb_addr, .pmb_wdata,
        .pmb_busy, .pmb_ack, .pmb_rdata, .pmb_fatal, .mem_addr, .row_strobe_n,
        .column_strobe_n, .write_select_n, .mem_dq_o, .mem_dq_oe, .mem_dq_i
    );
    dram_array_model u_dram_array_model
    (
        .hclk, .mem_addr, .row_strobe_n, .column_strobe_n, .write_select_n,
        .mem_dq_o, .mem_dq_oe, .flip, .mem_dq_i
    );
    initial
    begin
        forever #2.5 hclk = ~hclk;
    end
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cmp_flag(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask
    // wait for a flag under a bound, give up on expiry
    task wait_hi(input logic ahb_side);
        int i;
        i = 0;
        do
        begin
            @(posedge hclk);
            i++;
        end
        while ((ahb_side ? hreadyout : pmb_ack) !== 1'b1 && i < 20);
        if (ahb_side && hreadyout !== 1'b1)
        begin
            cmp_flag(1'b0, 1'b1);
            print_verdict;
        end
    endtask
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        wait_hi(1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_hi(1'b1);
        rd = hrdata;
    endtask
    task pmb(input logic w, input logic [29:0] a, input logic [31:0] d, input logic ok,
        input logic chk);
        pmb_valid <= 1'b1;
        pmb_write <= w;
        pmb_addr <= a;
        pmb_wdata <= d;
        if (ok)
            exp_q.push_back({chk, d});
        wait_hi(1'b0);
        if (ok && pmb_ack !== 1'b1)
        begin
            cmp_flag(1'b0, 1'b1);
            print_verdict;
        end
        pmb_valid <= 1'b0;
        repeat (5) @(posedge hclk);
    endtask
    function automatic logic [29:0] mk(input logic [17:0] ph, input logic [2:0] lo);
        return {ph, 9'h005, lo};
    endfunction
    always @(posedge hclk)
    begin
        if (pmb_ack === 1'b1 && exp_q.size() == 0)
            cmp_flag(1'b1, 1'b0);
        else if (pmb_ack === 1'b1)
        begin
            note = exp_q.pop_front();
            if (note[32])
                cmp_word(pmb_rdata, note[31:0]);
        end
    end
    initial
    begin
        logic [31:0] rd, d;
        logic [17:0] ph;
        logic [2:0] p;
        int m, b;
        void'($urandom(32'hf3f7));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, `MAP_OFS, 32'h0, rd);
        cmp_word(rd, `MAP_RESET);
        ahb(1'b0, 12'h040, 32'h0, rd);
        cmp_word(rd, 32'h0);
        d = $urandom;
        ph = 18'($urandom) & 18'h1ffff;
        ahb(1'b1, `MAP_OFS, 32'h29, rd);
        pmb(1'b1, mk(ph, 3'h0), d, 1'b0, 1'b0);
        ahb(1'b1, `MAP_OFS, 32'h28, rd);
        pmb(1'b1, mk(ph, 3'h0) ^ 30'h200, d, 1'b0, 1'b0);
        repeat (4)
        begin
            d = $urandom;
            ph = 18'($urandom) & 18'h1ffff;
            pmb(1'b1, mk(ph, 3'h0), d, 1'b1, 1'b0);
            pmb(1'b0, mk(ph, 3'h0), d, 1'b1, 1'b1);
        end
        ahb(1'b1, `HCAM_BASE, {13'h0, ph ^ 18'h1, 1'b1}, rd);
        flip <= 39'h1 << ($urandom % 32);
        pmb(1'b0, mk(ph, 3'h0), d, 1'b1, 1'b1);
        flip <= 39'h3;
        ahb(1'b0, `STAT_OFS, 32'h0, rd);
        cmp_word(rd, 32'h200);
        ahb(1'b0, `HCAM_BASE + 12'h4, 32'h0, rd);
        cmp_word(rd, {13'h0, ph, 1'b1});
        ahb(1'b0, `HRAM_BASE + 12'h4, 32'h0, rd);
        cmp_word(rd, d);
        d = ~d;
        pmb(1'b1, mk(ph, 3'h0), d, 1'b1, 1'b0);
        pmb(1'b0, mk(ph, 3'h0), d, 1'b1, 1'b1);
        ph = ph ^ 18'h2;
        ahb(1'b1, `HCAM_BASE + 12'h8, {13'h0, ph, 1'b0}, rd);
        pmb(1'b1, mk(ph, 3'h0), d, 1'b1, 1'b0);
        pmb(1'b0, mk(ph, 3'h0), d, 1'b1, 1'b0);
        flip <= 39'h0;
        cmp_flag(pmb_fatal, 1'b1);
        pmb(1'b1, mk(ph, 3'h0), d, 1'b0, 1'b0);
        ahb(1'b1, `STAT_OFS, 32'h2, rd);
        for (m = 2; m < 32; m++)
            ahb(1'b1, `HCAM_BASE + 12'(m * 4), {13'h0, 18'h30000 + 18'(m), 1'b1}, rd);
        ahb(1'b0, `STAT_OFS, 32'h0, rd);
        cmp_word(rd, 32'h2001);
        ph = ph ^ 18'h4;
        pmb(1'b1, mk(ph, 3'h0), d, 1'b1, 1'b0);
        flip <= 39'h1;
        pmb(1'b0, mk(ph, 3'h0), d, 1'b1, 1'b1);
        flip <= 39'h0;
        ahb(1'b0, `STAT_OFS, 32'h0, rd);
        cmp_word(rd, 32'h2001);
        ahb(1'b1, `HCAM_BASE + 12'h14, 32'h0, rd);
        ahb(1'b0, `STAT_OFS, 32'h0, rd);
        cmp_word(rd, 32'h1f00);
        ahb(1'b1, `HRAM_BASE + 12'h14, ~d, rd);
        ahb(1'b0, `HRAM_BASE + 12'h14, 32'h0, rd);
        cmp_word(rd, ~d);
        for (m = 1; m < 4; m++)
        begin
            p = 3'($urandom % (1 << m));
            ahb(1'b1, `MAP_OFS, {17'h0, p, 3'(m), 9'h028}, rd);
            pmb(1'b1, mk(ph, p) | 30'(m << 9), d, 1'b1, 1'b0);
            for (b = 0; b < 3; b++)
                pmb(1'b1, mk(ph, p ^ 3'(1 << b)) | 30'(m << 9), d, b >= m, 1'b0);
        end
        print_verdict;
    end
endmodule // tb
